// ---- include/frame_pkg.sv ----
// constants shared by the frame streamer and its helpers
package frame_pkg;
	// ============================================================
	// frame geometry
	localparam int          NUM_COLS     = 232;
	localparam int          ROWS         = 8;
	localparam int          PIX_BITS     = 4;
	localparam int          COL_BITS     = ROWS * PIX_BITS;
	localparam logic [31:0] SYNC_WORD    = 32'h0f0f2000;
	localparam logic [31:0] SYNC_TX      = 32'hf0f00200;
	localparam logic [5:0]  FILL_CYCLES  = 6'h28;
	// ============================================================
	// heat control layout
	localparam int          HEAT_REQ_BIT = 6;
	localparam int          HEAT_WD_BIT  = 5;
	localparam logic [7:0]  HEAT_RST     = 8'h00;
	// ============================================================
	// timing
	localparam longint      CLK_HZ       = 64'd10_000_000;
	localparam longint      HEAT_TIME_S  = 64'd1;
	localparam longint      HEAT_CYCLES  = HEAT_TIME_S * CLK_HZ;
	// ============================================================
	// link states, gray along idle -> fill -> stream
	typedef enum logic [1:0] {
		LINK_IDLE   = 2'b00,
		LINK_FILL   = 2'b01,
		LINK_STREAM = 2'b11
	} link_state_t;
endpackage

// ---- verilog/bit_sync.sv ----
// two-stage synchroniser for single-bit levels
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	// ============================================================
	// stage one is read by stage two only
	logic [W-1:0] meta;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // bit_sync
`default_nettype wire

// ---- verilog/pair_buffer.sv ----
// two-entry valid/ready buffer
`timescale 1ns/100ps
`default_nettype none
module pair_buffer #(
	parameter int W = 32
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         ce,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	// ============================================================
	// storage, indexed by read and write pointers
	logic [W-1:0] mem [2];
	logic         wr_ptr;
	logic         rd_ptr;
	logic [1:0]   count;
	wire          do_wr = ce && in_valid && in_ready;
	wire          do_rd = ce && out_valid && out_ready;

	assign in_ready  = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			if (do_wr)
				wr_ptr <= ~wr_ptr;
			if (do_rd)
				rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, do_wr} - {1'b0, do_rd};
		end
	end

	always_ff @(posedge clk) begin
		if (do_wr)
			mem[wr_ptr] <= in_data;
	end
endmodule // pair_buffer
`default_nettype wire

// ---- verilog/frame_streamer.sv ----
// sensor side of the fast port: heat control and frame streaming
`timescale 1ns/100ps
`default_nettype none
// What this block and the host do
// R1: host enters acquisition mode before collecting frames
// R2: heat control writes accepted only in acquisition
// R3: request plus watchdog heats for bounded time
// R4: first frame preceded by 40 dummy clocks
// R5: host drops first five bytes as filler
// R6: later frames follow with no dummy clocks
// R7: frame is sync column plus 232 columns
// R8: sync column carries the synchronisation word
// R9: columns in order, pixels top to bottom
// R10: pixel pairs sent nibble swapped
// R11: host widens each pixel to eight bits
// R12: host scales pixels by fifteen
// R13: host transposes columns into rows
// R14: host stores eight rows, dummy column dropped
// R15: host selects fast port, faster clock
// R16: host flags a sync mismatch
module frame_streamer
	import frame_pkg::*;
#(
	parameter longint HEAT_CNT = HEAT_CYCLES
) (
	input  wire logic                sys_clk,
	input  wire logic                nrst,
	input  wire logic                ce,
	input  wire logic                acq_mode,
	input  wire logic                heat_wr,
	input  wire logic [7:0]          heat_wdata,
	output logic      [7:0]          heat_control_reg,
	output logic                     heat_on,
	input  wire logic                col_valid,
	output logic                     col_ready,
	input  wire logic [COL_BITS-1:0] col_data,
	input  wire logic                link_sclk,
	input  wire logic                fast_port_select_n,
	output logic                     miso_out,
	output logic                     miso_oe
);
	// ============================================================
	// heat control, sys_clk domain
	logic [23:0] heat_cnt;
	wire         heat_take = ce && heat_wr && acq_mode;              // R2
	wire         heat_req  = heat_control_reg[HEAT_REQ_BIT];
	wire         heat_wd   = heat_control_reg[HEAT_WD_BIT];
	wire         heat_both = heat_wdata[HEAT_REQ_BIT] &&
	                         heat_wdata[HEAT_WD_BIT];
	wire         heat_end  = heat_req && heat_wd && (heat_cnt == 24'h1);

	// without the watchdog the heater runs until software stops it
	assign heat_on = heat_req && (!heat_wd || heat_cnt != 24'h0);   // R3

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			heat_control_reg <= HEAT_RST;
			heat_cnt         <= 24'h0;
		end else if (ce) begin
			if (heat_take) begin
				heat_control_reg <= heat_wdata;                          // R2
				heat_cnt <= heat_both ? 24'(HEAT_CNT) : 24'h0;           // R3
			end else if (heat_cnt != 24'h0) begin
				heat_cnt <= heat_cnt - 24'h1;                            // R3
				if (heat_end)
					heat_control_reg[HEAT_REQ_BIT] <= 1'b0;              // R3
			end
		end
	end

	// ============================================================
	// column buffer and handshake toward the link
	logic                buf_valid;
	logic                buf_ready;
	logic [COL_BITS-1:0] buf_data;
	logic [COL_BITS-1:0] mail_data;
	logic                mail_req;
	logic                ack_sys;
	logic                link_ack;
	wire                 mail_busy = (mail_req != ack_sys);

	assign buf_ready = !mail_busy;

	pair_buffer #(
		.W        (COL_BITS)
	) u_buf (
		.clk      (sys_clk),
		.nrst     (nrst),
		.ce       (ce),
		.in_valid (col_valid),
		.in_ready (col_ready),
		.in_data  (col_data),
		.out_valid(buf_valid),
		.out_ready(buf_ready),
		.out_data (buf_data)
	);

	bit_sync #(
		.W   (1)
	) u_ack_sync (
		.clk (sys_clk),
		.nrst(nrst),
		.d   (link_ack),
		.q   (ack_sys)
	);

	// mail_data is held steady until the link acknowledges it
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mail_req  <= 1'b0;
			mail_data <= '0;
		end else if (ce && buf_valid && buf_ready) begin
			mail_data <= buf_data;
			mail_req  <= ~mail_req;
		end
	end

	// ============================================================
	// link domain: synchronised inputs
	logic        sel_s;
	logic        acq_s;
	logic        req_s;

	bit_sync #(
		.W   (3)
	) u_link_sync (
		.clk (link_sclk),
		.nrst(nrst),
		// select is inverted so a cleared synchroniser reads as idle
		.d   ({!fast_port_select_n, acq_mode, mail_req}),
		.q   ({sel_s, acq_s, req_s})
	);

	// ============================================================
	// link domain: prefetch register and serialiser
	link_state_t         state;
	logic [4:0]          bit_cnt;
	logic [5:0]          fill_cnt;
	logic [7:0]          col_cnt;
	logic [31:0]         shreg;
	logic [COL_BITS-1:0] next_word;
	logic                next_full;
	logic [31:0]         tx_word;

	wire selected  = sel_s && acq_s;                                 // R1
	wire fill_done = (state == LINK_FILL) &&
	                 (fill_cnt == FILL_CYCLES - 6'h1);              // R4
	wire word_end  = (state == LINK_STREAM) && (bit_cnt == 5'h1f);
	wire frame_end = word_end && (col_cnt == 8'(NUM_COLS));         // R7
	wire consume   = word_end && !frame_end;
	wire capture   = (req_s != link_ack) && (!next_full || consume);

	// byte j leaves first for j = 0, rows 2j and 2j+1 in swapped nibbles
	genvar j;
	generate
		for (j = 0; j < ROWS / 2; j++) begin : g_swap
			assign tx_word[31 - 8*j -: 8] = {                             // R10
				next_word[PIX_BITS*(2*j) +: PIX_BITS],
				next_word[PIX_BITS*(2*j+1) +: PIX_BITS]
			};                                                            // R9
		end
	endgenerate

	assign miso_out = shreg[31];
	assign miso_oe  = sel_s;

	always_ff @(posedge link_sclk or negedge nrst) begin
		if (!nrst) begin
			next_word <= '0;
			next_full <= 1'b0;
			link_ack  <= 1'b0;
		end else if (capture) begin
			next_word <= mail_data;
			next_full <= 1'b1;
			link_ack  <= req_s;
		end else if (consume) begin
			next_full <= 1'b0;
		end
	end

	always_ff @(posedge link_sclk or negedge nrst) begin
		if (!nrst) begin
			state    <= LINK_IDLE;
			bit_cnt  <= 5'h0;
			fill_cnt <= 6'h0;
			col_cnt  <= 8'h0;
			shreg    <= 32'h0;
		end else if (!selected) begin
			state    <= LINK_IDLE;
			shreg    <= 32'h0;
		end else begin
			case (state)
				LINK_IDLE: begin
					state    <= LINK_FILL;                               // R4
					fill_cnt <= 6'h0;
					shreg    <= 32'h0;
				end
				LINK_FILL: begin
					fill_cnt <= fill_cnt + 6'h1;                         // R4
					if (fill_done) begin
						state   <= LINK_STREAM;
						shreg   <= SYNC_TX;                              // R8
						bit_cnt <= 5'h0;
						col_cnt <= 8'h0;
					end
				end
				LINK_STREAM: begin
					bit_cnt <= bit_cnt + 5'h1;
					if (frame_end) begin
						shreg   <= SYNC_TX;                              // R6
						col_cnt <= 8'h0;
					end else if (word_end) begin
						// a starved link sends black pixels, never a gap
						shreg   <= next_full ? tx_word : 32'h0;          // R6
						col_cnt <= col_cnt + 8'h1;                       // R9
					end else begin
						shreg   <= {shreg[30:0], 1'b0};
					end
				end
				default: begin
					state <= LINK_IDLE;
				end
			endcase
		end
	end

	// ============================================================
	// checks
	sequence s_fill_start;
		state == LINK_IDLE && selected;
	endsequence

	sequence s_fill_run;
		(state == LINK_FILL && selected) [*8];
	endsequence

	AST_HEAT_WRONG_MODE: assert property (@(posedge sys_clk) disable iff (!nrst) // R2
		ce && heat_wr && !acq_mode && !heat_end
		|=> $stable(heat_control_reg))
		else $error("heat control changed outside acquisition");

	AST_HEAT_BOUNDED: assert property (@(posedge sys_clk) disable iff (!nrst) // R3
		ce && heat_end && !heat_wr |=> !heat_on)
		else $error("heater still on after watchdog expiry");

	AST_HEAT_START: assert property (@(posedge sys_clk) disable iff (!nrst) // R3
		heat_take && heat_both |=> heat_on && heat_cnt == 24'(HEAT_CNT))
		else $error("heater did not start on request");

	AST_FILL_QUIET: assert property (@(posedge link_sclk) disable iff (!nrst) // R4
		s_fill_start |=> s_fill_run and (miso_out == 1'b0) [*8])
		else $error("dummy clocks not quiet");

	AST_FILL_LEN: assert property (@(posedge link_sclk) disable iff (!nrst) // R4
		state == LINK_FILL && fill_cnt == 6'h27 && selected
		|=> state == LINK_STREAM && shreg == SYNC_TX)
		else $error("sync not after forty dummy clocks");

	AST_NO_GAP: assert property (@(posedge link_sclk) disable iff (!nrst) // R6
		frame_end && selected |=> state == LINK_STREAM && col_cnt == 8'h0
		&& bit_cnt == 5'h0)
		else $error("gap between frames");

	AST_FRAME_LEN: assert property (@(posedge link_sclk) disable iff (!nrst) // R7
		state == LINK_STREAM |-> col_cnt <= 8'(NUM_COLS))
		else $error("column count past frame end");

	AST_SYNC_SWAP: assert property (@(posedge link_sclk) disable iff (!nrst) // R10
		frame_end && selected
		|=> shreg == {SYNC_WORD[27:24], SYNC_WORD[31:28], SYNC_WORD[19:16],
		            SYNC_WORD[23:20], SYNC_WORD[11:8], SYNC_WORD[15:12],
		            SYNC_WORD[3:0], SYNC_WORD[7:4]})
		else $error("sync word not nibble swapped");

	AST_COL_ADVANCE: assert property (@(posedge link_sclk) disable iff (!nrst) // R9
		consume && selected |=> col_cnt == $past(col_cnt) + 8'h1)
		else $error("column order broken");
endmodule // frame_streamer
`default_nettype wire

// ---- sim/host_port.sv ----
// host model of the fast serial port: clock, select, frame capture
`timescale 1ns/100ps
`default_nettype none
module host_port
	import frame_pkg::*;
(
	input  wire logic run,
	input  wire logic sel,
	input  wire logic miso_out,
	input  wire logic miso_oe,
	output logic      link_sclk,
	output logic      fast_port_select_n
);
	logic [31:0] sh = 32'h0;
	logic [7:0]  b;
	logic [7:0]  image [ROWS][NUM_COLS];
	int          bits, nb, col, sync_pos = 0, frames = 0, sync_err = 0;
	// ============================================================
	// link clock
	// clock stands still unless a transfer is wanted
	logic sclk = 1'b0;
	always begin
		if (run) begin
			#15 sclk = 1'b1;
			#15 sclk = 1'b0;
		end else
			#15;
	end
	assign link_sclk = sclk;
	assign fast_port_select_n = !sel;
	// ============================================================
	// capture
	// sample mid-bit; the design launches on the rising edge
	always @(negedge link_sclk) begin
		if (fast_port_select_n || !miso_oe) begin
			bits = 0;
			sh = 32'h0;
			col = -1;
			nb = 0;
		end else begin
			sh = {sh[30:0], miso_out};
			bits++;
			if (col < 0) begin
				// leading zeros are pipeline filler
				if (sh === SYNC_TX) begin
					sync_pos = bits;
					col = 1;
					frames++;
				end
			end else if (++nb == 32) begin
				nb = 0;
				if (col == 0) begin
					frames++;
					if (sh !== SYNC_TX) sync_err++;
				end else
					for (int j = 0; j < 4; j++) begin
						b = sh[31-8*j -: 8];
						image[2*j][col-1] = {4'h0, b[7:4]} * 8'hf;
						image[2*j+1][col-1] = {4'h0, b[3:0]} * 8'hf;
					end
				col = (col == NUM_COLS) ? 0 : col + 1;
			end
		end
	end
endmodule // host_port
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the frame streamer
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import frame_pkg::*;
;
	localparam longint HCNT = 20;
	logic        sys_clk = 1'b0, nrst = 1'b0, ce = 1'b1, acq_mode = 1'b0;
	logic        heat_wr = 1'b0, col_valid = 1'b0, run = 1'b1, sel = 1'b0;
	logic [7:0]  heat_wdata = 8'h00, heat_control_reg;
	logic        heat_on, col_ready, link_sclk, fast_port_select_n;
	logic        miso_out, miso_oe;
	logic [31:0] col_data = 32'h0;
	int          miscompares = 0, compares = 0, idx = 0, n;

	always #50 sys_clk = ~sys_clk;

	frame_streamer #(.HEAT_CNT(HCNT)) i_frame_streamer (
		.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .acq_mode(acq_mode),
		.heat_wr(heat_wr), .heat_wdata(heat_wdata),
		.heat_control_reg(heat_control_reg), .heat_on(heat_on),
		.col_valid(col_valid), .col_ready(col_ready), .col_data(col_data),
		.link_sclk(link_sclk), .fast_port_select_n(fast_port_select_n),
		.miso_out(miso_out), .miso_oe(miso_oe));
	host_port i_host_port (.run(run), .sel(sel), .miso_out(miso_out),
		.miso_oe(miso_oe), .link_sclk(link_sclk),
		.fast_port_select_n(fast_port_select_n));
	// ============================================================
	// helpers
	function automatic logic [31:0] col_word(input int c);
		return 32'h76543210 ^ {4{c[7:0]}};
	endfunction
	// column feeder; the index moves only once a word was taken
	always @(posedge sys_clk)
		if (col_valid && col_ready && ce)
			idx <= (idx == NUM_COLS - 1) ? 0 : idx + 1;
	always @(negedge sys_clk)
		col_data <= col_word(idx);

	task check(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask

	task finish_test;
		if (miscompares == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task heat_write(input logic [7:0] d);
		@(negedge sys_clk);
		heat_wr = 1'b1;
		heat_wdata = d;
		@(negedge sys_clk);
		heat_wr = 1'b0;
	endtask
	// ============================================================
	// scenarios
	task test_heat;
		heat_write(8'h60);
		check(heat_control_reg, 8'h00, "write outside acquisition");
		acq_mode = 1'b1;
		heat_write(8'h60);
		check(heat_control_reg, 8'h60, "heat register");
		n = 0;
		while (heat_on === 1'b1 && n < 40) begin
			n++;
			@(negedge sys_clk);
		end
		check(n >= HCNT - 1 && n <= HCNT + 1, 1'b1, "heat time");
		check(heat_control_reg[HEAT_REQ_BIT], 1'b0, "request kept");
		heat_write(8'h40);
		repeat (2 * HCNT) @(negedge sys_clk);
		check(heat_on, 1'b1, "heat without watchdog");
		heat_write(8'h00);
		check(heat_on, 1'b0, "heat off");
		ce = 1'b0;
		heat_write(8'h60);
		check(heat_control_reg, 8'h00, "write while frozen");
		ce = 1'b1;
	endtask

	// reselect repeats the fill, so the second pass checks framing only
	task test_stream(input int k);
		int tgt;
		tgt = i_host_port.frames + 3;
		i_host_port.sync_pos = 0;
		col_valid = 1'b1;
		run = 1'b1;
		sel = 1'b1;
		n = 0;
		while (i_host_port.frames < tgt && n < 12000) begin
			n++;
			@(negedge sys_clk);
		end
		if (n == 12000) begin
			miscompares++;
			finish_test;
		end
		check(i_host_port.sync_pos >= 72 && i_host_port.sync_pos <= 76,
			1'b1, "fill length");
		check(i_host_port.sync_err, 0, "frame sync");
		if (k == 0)
			for (int c = 0; c < NUM_COLS; c++)
				for (int r = 0; r < ROWS; r++)
					check(i_host_port.image[r][c],
						((col_word(c) >> (4 * r)) & 32'hf) * 15, "pixel");
		sel = 1'b0;
		repeat (4) @(negedge sys_clk);
		check(miso_oe, 1'b0, "pin released");
		run = 1'b0;
	endtask
	// ============================================================
	// main sequence
	initial begin
		repeat (20) @(negedge sys_clk);
		check(heat_control_reg, HEAT_RST, "reset heat register");
		check(heat_on, 1'b0, "reset heater");
		check(miso_oe, 1'b0, "reset enable");
		check(col_ready, 1'b1, "reset ready");
		nrst = 1'b1;
		run = 1'b0;
		test_heat;
		test_stream(0);
		test_stream(1);
		finish_test;
	end
endmodule // tb_top
`default_nettype wire
